// File: src/hscd_strap_decoder.sv
// strap capture and decode for a four-port hub
//
// Behaviour
// - capture all straps when power-on or chip reset is released; use as default
// - pull-ups on both serial data-out and clock select management slave mode
// - no pull on serial data-out and clock selects serial ROM mode
// - shared pins: ROM enable/din/dout/clk, or two straps, mgmt data, mgmt clock
// - positive-line strap 0 enables D+, 1 disables it, per port
// - negative-line strap 0 enables D-, 1 disables it, per port
// - port disabled only when both its line straps are high
// - a strap-disabled USB 2.0 port also disables its USB 3.1 function
// - five-level fixed-port strap gives zero to four non-removable ports
// - five-level charging strap gives zero to four charging ports
// - internal pulls stay enabled at all times
// - after capture go to external config if mgmt mode, else OTP config
`timescale 1ns/1ps
`default_nettype none
`include "hscd_params.svh"
module hscd_strap_decoder
   import hscd_pkg::*;
(
   input  wire logic         clk,          // 125 MHz core clock
   input  wire logic         rst,          // power-on reset, async high
   input  wire logic         chip_rst_n,   // external chip reset pin
   input  wire hscd_straps_s straps_pin,   // sensed strap levels
   input  wire logic         rom_sig_ok,   // ROM signature checked valid
   output logic              cfg_valid,    // straps captured and decoded
   output hscd_cfg_s         cfg,          // decoded configuration
   output hscd_mode_e        pin_mode,     // shared pin function set
   output logic              rom_enable,   // serial ROM path in use
   output hscd_stage_e       boot_stage,   // boot stage after strap read
   output logic              pulls_en      // internal pulls enabled
);

   // five-level strap to port mask of ports 1..n
   function automatic logic [3:0] lvl_to_mask(input logic [2:0] lvl);
      case (lvl)
         `HSCD_LVL_PD_WEAK: lvl_to_mask = 4'h0;
         `HSCD_LVL_PU_WEAK: lvl_to_mask = 4'h1;
         `HSCD_LVL_PD_MID:  lvl_to_mask = 4'h3;
         `HSCD_LVL_PU_MID:  lvl_to_mask = 4'h7;
         `HSCD_LVL_PD_HARD: lvl_to_mask = 4'hf;
         default:           lvl_to_mask = 4'h0;
      endcase
   endfunction

   hscd_straps_s straps_m_reg;
   hscd_straps_s straps_s_reg;
   logic         chip_m_reg;
   logic         chip_s_reg;
   logic         chip_d_reg;
   logic         chip_rel;
   hscd_cfg_s    cfg_next;
   hscd_stage_e  stage_reg;
   hscd_stage_e  stage_next;

   // two-flop sync of pins from outside the clock domain
   // only the second flop of each pair is read by any logic
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         straps_m_reg <= '0;
         straps_s_reg <= '0;
         chip_m_reg   <= 1'b0;
         chip_s_reg   <= 1'b0;
         chip_d_reg   <= 1'b0;
      end
      else
      begin
         straps_m_reg <= straps_pin;
         straps_s_reg <= straps_m_reg;
         chip_m_reg   <= chip_rst_n;
         chip_s_reg   <= chip_m_reg;
         chip_d_reg   <= chip_s_reg;
      end
   end

   // chip reset release seen on the synced level
   assign chip_rel = chip_s_reg & ~chip_d_reg;

   // decode of the synced straps
   always_comb
   begin
      cfg_next           = '0;
      cfg_next.mgmt_mode = (straps_s_reg.dout_sense == `HSCD_SNS_PULLUP) &&
                           (straps_s_reg.clk_sense == `HSCD_SNS_PULLUP);
      cfg_next.dplus_off  = straps_s_reg.port_dplus_off_strap;
      cfg_next.dminus_off = straps_s_reg.port_dminus_off_strap;
      cfg_next.usb2_port_off = straps_s_reg.port_dplus_off_strap &
                               straps_s_reg.port_dminus_off_strap;
      cfg_next.usb3_port_off = cfg_next.usb2_port_off;
      cfg_next.fixed_ports =
         lvl_to_mask(straps_s_reg.fixed_port_count_strap);
      cfg_next.charging_ports =
         lvl_to_mask(straps_s_reg.charging_ports_strap);
   end

   // boot stage sequencing
   always_comb
   begin
      case (stage_reg)
         HSCD_ST_RESET:   stage_next = HSCD_ST_CAPTURE;
         HSCD_ST_CAPTURE: stage_next = cfg_next.mgmt_mode ?
                             HSCD_ST_EXT_CFG : HSCD_ST_OTP_CFG;
         HSCD_ST_EXT_CFG: stage_next = HSCD_ST_EXT_CFG;
         HSCD_ST_OTP_CFG: stage_next = HSCD_ST_OTP_CFG;
         default:         stage_next = HSCD_ST_RESET;
      endcase
   end

   // stage register; chip reset held low restarts the sequence
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         stage_reg <= HSCD_ST_RESET;
      else if (!chip_s_reg)
         stage_reg <= HSCD_ST_RESET;
      else if (stage_reg == HSCD_ST_RESET && !chip_rel && cfg_valid)
         stage_reg <= stage_reg;
      else
         stage_reg <= stage_next;
   end

   // capture once per release; held until the next reset
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cfg       <= '0;
         cfg_valid <= 1'b0;
      end
      else if (!chip_s_reg)
      begin
         cfg       <= '0;
         cfg_valid <= 1'b0;
      end
      else if (stage_reg == HSCD_ST_CAPTURE)
      begin
         cfg       <= cfg_next;
         cfg_valid <= 1'b1;
      end
   end

   // pin function, ROM enable and stage outputs
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pin_mode   <= HSCD_FN_SPI;
         rom_enable <= 1'b0;
         boot_stage <= HSCD_ST_RESET;
         pulls_en   <= 1'b1;
      end
      else
      begin
         pin_mode   <= cfg.mgmt_mode ? HSCD_FN_MGMT : HSCD_FN_SPI;
         rom_enable <= cfg_valid && !cfg.mgmt_mode && rom_sig_ok;
         boot_stage <= stage_reg;
         pulls_en   <= 1'b1;
      end
   end

   // steps of the strap read: release seen, then the read stage
   sequence s_release;
      chip_rel && stage_reg == HSCD_ST_RESET;
   endsequence
   sequence s_strap_read;
      stage_reg == HSCD_ST_CAPTURE && chip_s_reg;
   endsequence

   // capture and hold of the decoded set
   a_hold_cfg: assert property (@(posedge clk) disable iff (rst)
      (cfg_valid && chip_s_reg && $past(cfg_valid) && $past(chip_s_reg))
      |-> $stable(cfg)) else $error("config changed after capture");
   a_capture: assert property (@(posedge clk) disable iff (rst)
      (chip_rel) |-> ##[1:3] cfg_valid || !chip_s_reg)
      else $error("no capture after release");
   a_release_read: assert property (@(posedge clk) disable iff (rst)
      s_release |=> stage_reg == HSCD_ST_CAPTURE)
      else $error("no strap read after release");
   a_read_load: assert property (@(posedge clk) disable iff (rst)
      s_release ##1 s_strap_read |=> cfg_valid)
      else $error("strap read did not load");
   a_valid_src: assert property (@(posedge clk) disable iff (rst)
      $rose(cfg_valid) |-> $past(stage_reg == HSCD_ST_CAPTURE))
      else $error("config valid outside strap read");
   a_valid_hold: assert property (@(posedge clk) disable iff (rst)
      cfg_valid && chip_s_reg |=> cfg_valid)
      else $error("config valid dropped");
   a_chip_clear: assert property (@(posedge clk) disable iff (rst)
      !chip_s_reg |=> !cfg_valid && cfg == '0 && stage_reg == HSCD_ST_RESET)
      else $error("chip reset did not clear");

   // serial pin mode from the two sense codes
   a_mode_decode: assert property (@(posedge clk) disable iff (rst)
      s_strap_read |=> cfg.mgmt_mode ==
      ($past(straps_s_reg.dout_sense) == `HSCD_SNS_PULLUP &&
       $past(straps_s_reg.clk_sense) == `HSCD_SNS_PULLUP))
      else $error("serial mode decode wrong");
   a_serial_rom: assert property (@(posedge clk) disable iff (rst)
      s_strap_read ##0 (straps_s_reg.dout_sense == `HSCD_SNS_FLOAT &&
      straps_s_reg.clk_sense == `HSCD_SNS_FLOAT) |=> !cfg.mgmt_mode)
      else $error("floating serial pins not rom mode");
   a_pin_func: assert property (@(posedge clk) disable iff (rst)
      pin_mode == ($past(cfg.mgmt_mode) ? HSCD_FN_MGMT : HSCD_FN_SPI))
      else $error("shared pin function wrong");

   // serial rom path use
   a_rom_use: assert property (@(posedge clk) disable iff (rst)
      rom_enable |-> $past(rom_sig_ok) && !$past(cfg.mgmt_mode))
      else $error("rom used without signature");
   a_rom_mgmt: assert property (@(posedge clk) disable iff (rst)
      cfg.mgmt_mode |=> !rom_enable)
      else $error("rom used in management mode");
   a_rom_on: assert property (@(posedge clk) disable iff (rst)
      cfg_valid && !cfg.mgmt_mode && rom_sig_ok |=> rom_enable)
      else $error("rom path not enabled");

   // per-port line disables and the tied usb3 disable
   a_dplus_copy: assert property (@(posedge clk) disable iff (rst)
      s_strap_read |=>
      cfg.dplus_off == $past(straps_s_reg.port_dplus_off_strap))
      else $error("positive-line disable wrong");
   a_dminus_copy: assert property (@(posedge clk) disable iff (rst)
      s_strap_read |=>
      cfg.dminus_off == $past(straps_s_reg.port_dminus_off_strap))
      else $error("negative-line disable wrong");
   a_port_off: assert property (@(posedge clk) disable iff (rst)
      cfg.usb2_port_off == (cfg.dplus_off & cfg.dminus_off))
      else $error("port disable not both lines");
   a_usb3_off: assert property (@(posedge clk) disable iff (rst)
      cfg.usb3_port_off == cfg.usb2_port_off)
      else $error("usb3 disable not tied");

   // five-level strap decodes, one check per level per strap, then the mask shape checks
   a_fixed_none: assert property (@(posedge clk) disable iff (rst)
      s_strap_read ##0
      (straps_s_reg.fixed_port_count_strap == `HSCD_LVL_PD_WEAK)
      |=> cfg.fixed_ports == 4'h0)
      else $error("fixed ports wrong for weak pull-down");
   a_fixed_one: assert property (@(posedge clk) disable iff (rst)
      s_strap_read ##0
      (straps_s_reg.fixed_port_count_strap == `HSCD_LVL_PU_WEAK)
      |=> cfg.fixed_ports == 4'h1)
      else $error("fixed ports wrong for weak pull-up");
   a_fixed_two: assert property (@(posedge clk) disable iff (rst)
      s_strap_read ##0
      (straps_s_reg.fixed_port_count_strap == `HSCD_LVL_PD_MID)
      |=> cfg.fixed_ports == 4'h3)
      else $error("fixed ports wrong for mid pull-down");
   a_fixed_three: assert property (@(posedge clk) disable iff (rst)
      s_strap_read ##0
      (straps_s_reg.fixed_port_count_strap == `HSCD_LVL_PU_MID)
      |=> cfg.fixed_ports == 4'h7)
      else $error("fixed ports wrong for mid pull-up");
   a_fixed_all: assert property (@(posedge clk) disable iff (rst)
      s_strap_read ##0
      (straps_s_reg.fixed_port_count_strap == `HSCD_LVL_PD_HARD)
      |=> cfg.fixed_ports == 4'hf)
      else $error("fixed ports wrong for hard pull-down");
   a_chg_none: assert property (@(posedge clk) disable iff (rst)
      s_strap_read ##0
      (straps_s_reg.charging_ports_strap == `HSCD_LVL_PD_WEAK)
      |=> cfg.charging_ports == 4'h0)
      else $error("charging wrong for weak pull-down");
   a_chg_one: assert property (@(posedge clk) disable iff (rst)
      s_strap_read ##0
      (straps_s_reg.charging_ports_strap == `HSCD_LVL_PU_WEAK)
      |=> cfg.charging_ports == 4'h1)
      else $error("charging wrong for weak pull-up");
   a_chg_two: assert property (@(posedge clk) disable iff (rst)
      s_strap_read ##0
      (straps_s_reg.charging_ports_strap == `HSCD_LVL_PD_MID)
      |=> cfg.charging_ports == 4'h3)
      else $error("charging wrong for mid pull-down");
   a_chg_three: assert property (@(posedge clk) disable iff (rst)
      s_strap_read ##0
      (straps_s_reg.charging_ports_strap == `HSCD_LVL_PU_MID)
      |=> cfg.charging_ports == 4'h7)
      else $error("charging wrong for mid pull-up");
   a_chg_all: assert property (@(posedge clk) disable iff (rst)
      s_strap_read ##0
      (straps_s_reg.charging_ports_strap == `HSCD_LVL_PD_HARD)
      |=> cfg.charging_ports == 4'hf)
      else $error("charging wrong for hard pull-down");
   a_fixed_mask: assert property (@(posedge clk) disable iff (rst)
      (cfg.fixed_ports & (cfg.fixed_ports + 4'h1)) == 4'h0)
      else $error("fixed port mask not contiguous");
   a_chg_mask: assert property (@(posedge clk) disable iff (rst)
      (cfg.charging_ports & (cfg.charging_ports + 4'h1)) == 4'h0)
      else $error("charging mask not contiguous");

   // boot stage after the strap read
   a_stage_next: assert property (@(posedge clk) disable iff (rst)
      (stage_reg == HSCD_ST_CAPTURE && chip_s_reg) |=>
      (stage_reg == (cfg.mgmt_mode ? HSCD_ST_EXT_CFG : HSCD_ST_OTP_CFG)))
      else $error("wrong stage after strap read");
   a_stage_hold: assert property (@(posedge clk) disable iff (rst)
      (stage_reg == HSCD_ST_EXT_CFG || stage_reg == HSCD_ST_OTP_CFG) &&
      chip_s_reg |=> $stable(stage_reg))
      else $error("boot stage left without reset");
   a_stage_onehot: assert property (@(posedge clk) disable iff (rst)
      $onehot(stage_reg)) else $error("boot stage not one-hot");
   a_boot_follow: assert property (@(posedge clk) disable iff (rst)
      boot_stage == $past(stage_reg))
      else $error("boot stage output lags wrong");

   // internal pulls
   a_pulls: assert property (@(posedge clk) disable iff (rst)
      pulls_en) else $error("pulls disabled");

endmodule
`default_nettype wire

// File: src/hscd_params.svh
// constants for the hub strap configuration decoder
`ifndef HSCD_PARAMS_SVH
`define HSCD_PARAMS_SVH
`define HSCD_PORTS       4
`define HSCD_LVL_W       3
// sensed five-level strap codes, from the pin sense front end
`define HSCD_LVL_PD_WEAK 3'h0
`define HSCD_LVL_PU_WEAK 3'h1
`define HSCD_LVL_PD_MID  3'h2
`define HSCD_LVL_PU_MID  3'h3
`define HSCD_LVL_PD_HARD 3'h4
// three-level sense codes on the serial mode pins
`define HSCD_SNS_FLOAT   2'h0
`define HSCD_SNS_PULLUP  2'h1
`define HSCD_SNS_PULLDN  2'h2
`endif

// File: src/hscd_pkg.sv
// types for the hub strap configuration decoder
package hscd_pkg;
   typedef enum logic [3:0] {
      HSCD_ST_RESET   = 4'b0001,
      HSCD_ST_CAPTURE = 4'b0010,
      HSCD_ST_EXT_CFG = 4'b0100,
      HSCD_ST_OTP_CFG = 4'b1000
   } hscd_stage_e;
   typedef enum logic [1:0] {
      HSCD_FN_SPI  = 2'b01,
      HSCD_FN_MGMT = 2'b10
   } hscd_mode_e;
   typedef struct packed {
      logic [1:0] dout_sense;
      logic [1:0] clk_sense;
      logic [2:0] fixed_port_count_strap;
      logic [2:0] charging_ports_strap;
      logic [3:0] port_dplus_off_strap;
      logic [3:0] port_dminus_off_strap;
   } hscd_straps_s;
   typedef struct packed {
      logic       mgmt_mode;
      logic [3:0] dplus_off;
      logic [3:0] dminus_off;
      logic [3:0] usb2_port_off;
      logic [3:0] usb3_port_off;
      logic [3:0] fixed_ports;
      logic [3:0] charging_ports;
   } hscd_cfg_s;
endpackage

// File: verification/hscd_board_straps.sv
// board strap resistor model feeding the sensed strap levels
`timescale 1ns/1ps
`default_nettype none
module hscd_board_straps
   import hscd_pkg::*;
(
   input  wire hscd_straps_s setting,    // resistors fitted on the board
   input  wire logic         rom_good,   // attached rom holds signature
   output hscd_straps_s      straps_pin, // levels seen by the sensers
   output logic              rom_sig_ok  // signature check outcome
);
   // the fitted strap setting passes straight through to the sensed levels
   assign straps_pin = setting;
   // signature presence decides whether the rom path may be used
   assign rom_sig_ok = rom_good;
endmodule
`default_nettype wire

// File: verification/tb_hscd_strap_decoder.sv
// self-checking bench for the strap capture and decode block
`timescale 1ns/1ps
`default_nettype none
module tb_hscd_strap_decoder
   import hscd_pkg::*;
;
   logic         clk, rst, chip_rst_n, sig_want, rom_sig_ok;
   logic         cfg_valid, rom_enable, pulls_en;
   hscd_straps_s want, straps_pin;
   hscd_cfg_s    cfg, exp;
   hscd_mode_e   pin_mode;
   hscd_stage_e  boot_stage;
   int           bad_count, n_checks;
   logic [1:0]   ds [5] = '{2'h1, 2'h0, 2'h1, 2'h2, 2'h1};
   logic [1:0]   cs [5] = '{2'h1, 2'h0, 2'h0, 2'h2, 2'h1};

   hscd_board_straps hscd_board_straps_inst (.setting(want),
      .rom_good(sig_want), .straps_pin(straps_pin), .rom_sig_ok(rom_sig_ok));
   hscd_strap_decoder hscd_strap_decoder_inst (.clk(clk), .rst(rst),
      .chip_rst_n(chip_rst_n), .straps_pin(straps_pin),
      .rom_sig_ok(rom_sig_ok), .cfg_valid(cfg_valid), .cfg(cfg),
      .pin_mode(pin_mode), .rom_enable(rom_enable),
      .boot_stage(boot_stage), .pulls_en(pulls_en));

   // free running core clock
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic cmp_cfg(input hscd_cfg_s got, input hscd_cfg_s w);
      n_checks++;
      if (got !== w)
      begin
         bad_count++;
         $display("unexpected at %0t got %h want %h", $time, got, w);
      end
   endtask

   task automatic cmp4(input logic [3:0] got, input logic [3:0] w);
      n_checks++;
      if (got !== w)
      begin
         bad_count++;
         $display("unexpected at %0t got %h want %h", $time, got, w);
      end
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // bounded wait for the decoded set; a timeout counts as a mismatch
   task automatic wait_valid(output bit ok);
      int k;
      for (k = 0; k < 20 && cfg_valid !== 1'b1; k++)
         @(negedge clk);
      ok = (cfg_valid === 1'b1);
      if (!ok)
         bad_count++;
   endtask

   // chip reset pulse with a new strap setting, then decode checks
   task automatic capture(input int i);
      bit   ok;
      logic mg;
      mg = (ds[i] == 2'h1) && (cs[i] == 2'h1);
      @(negedge clk);
      chip_rst_n = 1'b0;
      want = '{ds[i], cs[i], 3'(i), 3'(4 - i), 4'(i * 3), 4'(i * 5)};
      sig_want = (i != 2);
      exp = '{mg, 4'(i * 3), 4'(i * 5), 4'(i * 3) & 4'(i * 5),
              4'(i * 3) & 4'(i * 5), 4'((1 << i) - 1),
              4'((1 << (4 - i)) - 1)};
      repeat (4) @(negedge clk);
      chip_rst_n = 1'b1;
      wait_valid(ok);
      if (!ok)
         return;
      repeat (2) @(negedge clk);
      cmp_cfg(cfg, exp);
      cmp4({2'h0, pin_mode}, mg ? 4'h2 : 4'h1);
      cmp4(boot_stage, mg ? 4'h4 : 4'h8);
      cmp4({3'h0, rom_enable}, {3'h0, ~mg & sig_want});
      want = ~want;
      repeat (4) @(negedge clk);
      cmp_cfg(cfg, exp);
      cmp4({3'h0, cfg_valid}, 4'h1);
   endtask

   // reset, then one capture for every strap level code
   initial
   begin
      bit ok;
      rst = 1'b1;
      chip_rst_n = 1'b1;
      sig_want = 1'b0;
      want = '0;
      bad_count = 0;
      n_checks = 0;
      repeat (20) @(negedge clk);
      cmp4({3'h0, cfg_valid}, 4'h0);
      cmp4(boot_stage, 4'h1);
      cmp4({3'h0, pulls_en}, 4'h1);
      rst = 1'b0;
      // power-on release captures the all-zero setting
      wait_valid(ok);
      repeat (2) @(negedge clk);
      cmp_cfg(cfg, '0);
      cmp4(boot_stage, 4'h8);
      for (int i = 0; i < 5; i++)
         capture(i);
      // mid-run power-on reset clears, then recaptures the inverted setting left by the last capture
      rst = 1'b1;
      repeat (2) @(negedge clk);
      cmp4({3'h0, cfg_valid}, 4'h0);
      cmp4({2'h0, pin_mode}, 4'h1);
      cmp4(boot_stage, 4'h1);
      rst = 1'b0;
      wait_valid(ok);
      repeat (2) @(negedge clk);
      // code 7 on the charging strap lies outside the five levels
      cmp_cfg(cfg, '{1'b0, 4'h3, 4'hb, 4'h3, 4'h3, 4'h7, 4'h0});
      cmp4(boot_stage, 4'h8);
      cmp4({3'h0, rom_enable}, 4'h1);
      cmp4({3'h0, pulls_en}, 4'h1);
      final_report();
   end
endmodule
`default_nettype wire
